/* File: rtl/sce_host_ctrl.sv */
// Function
// - Sleep after programmed idle interval when enabled
// - Wake on 2 ms trigger or receive activity
// - Buzzer high while decoded data is sent
// - Standby scan bounded by 120 ms
// - Initialization within 310 ms, then power-up beep, then standby
// - Wake plus decode bounded near 120 ms
// - Serial 9600 baud, 8N1, no handshake
// - Scan from trigger pin or serial command
// - Power-up indication on buzzer
// - Illumination on during capture
// - Good read: light off, buzzer, send
// - Pin scan until decode, release or timeout; re-press
`timescale 1ns/1ps
`default_nettype none
`include "sce_params.svh"

module sce_host_ctrl
  import sce_pkg::*;
#(
  parameter int INIT_CYC = `SCE_INIT_MS * `SCE_CLK_KHZ,
  parameter int BEEP_CYC = `SCE_BEEP_MS * `SCE_CLK_KHZ,
  parameter int WAKE_CYC = `SCE_WAKE_MS * `SCE_CLK_KHZ,
  parameter int SCAN_CYC = `SCE_SCAN_MS * `SCE_CLK_KHZ,
  parameter int MS_CYC   = `SCE_CLK_KHZ,
  parameter int BIT_CYC  = `SCE_BIT_CYC
) (
  input  wire logic      clock,
  input  wire logic      rst_b,
  input  wire logic      trigPin_b,
  input  wire logic      rxdPin,
  input  wire logic      sleepEn,
  input  wire sce_idle_t sleepMs,
  input  wire logic      decodeDone,
  input  wire sce_byte_s decByte,
  output logic           decReady,
  output logic           illumOn,
  output logic           buzzer,
  output logic           txdPin,
  output logic           sleepActive
);

  sce_state_e state_ff;
  sce_state_e nxt_state;
  sce_tmr_t   tmr_ff;
  sce_tmr_t   nxt_tmr;
  sce_ms_t    msCnt_ff;
  sce_ms_t    nxt_msCnt;
  sce_idle_t  idleMs_ff;
  sce_idle_t  nxt_idleMs;
  logic       swScan_ff;
  logic       nxt_swScan;
  logic       lastSent_ff;
  logic       nxt_lastSent;
  logic       trigMeta_ff;
  logic       trigSync_ff;
  logic       illum_ff;
  logic       buzz_ff;
  logic       sleep_ff;
  logic       trigLow;
  logic       txReady;
  logic       rxAct;
  logic       swCmd;
  logic       accept;
  logic       active;
  sce_byte_s  rxByte;
  sce_byte_s  txIn;

  // Timer reaches the last cycle of a span
  function automatic logic tmrAt(sce_tmr_t t, int span);
    return t == sce_tmr_t'(span - 1);
  endfunction

  assign trigLow = ~trigSync_ff;
  assign swCmd   = rxByte.valid
                   && rxByte.data == `SCE_SW_TRIG;

  // Decoded bytes go straight to the line, one at a time
  assign decReady = (state_ff == SCE_SEND) && txReady;
  assign accept   = decReady && decByte.valid;
  always_comb begin
    txIn       = decByte;
    txIn.valid = accept;
  end

  sce_uart_tx #(
    .BIT_CYC (BIT_CYC)
  ) u_tx (
    .clock   (clock),
    .rst_b   (rst_b),
    .txIn    (txIn),
    .txReady (txReady),
    .txd     (txdPin)
  );

  sce_uart_rx #(
    .BIT_CYC (BIT_CYC)
  ) u_rx (
    .clock  (clock),
    .rst_b  (rst_b),
    .rxdPin (rxdPin),
    .rxByte (rxByte),
    .rxAct  (rxAct)
  );

  // Operating sequence; its timers share one counter to save flops
  always_comb begin
    nxt_state    = state_ff;
    nxt_tmr      = tmr_ff + sce_tmr_t'(1);
    nxt_swScan   = swScan_ff;
    nxt_lastSent = lastSent_ff | (accept & decByte.last);
    unique case (state_ff)
      SCE_INIT: begin
        if (tmrAt(tmr_ff, INIT_CYC)) begin
          nxt_state = SCE_BEEP;
          nxt_tmr   = '0;
        end
      end
      SCE_BEEP: begin
        if (tmrAt(tmr_ff, BEEP_CYC)) begin
          nxt_state = SCE_STBY;
        end
      end
      SCE_STBY: begin
        nxt_tmr = '0;
        if (trigLow || swCmd) begin
          nxt_state  = SCE_SCAN;
          nxt_swScan = ~trigLow;
        end else if (sleepEn && idleMs_ff >= sleepMs) begin
          nxt_state = SCE_SLEEP;
        end
      end
      SCE_SCAN: begin
        nxt_lastSent = 1'b0;
        if (decodeDone) begin
          nxt_state = SCE_SEND;
        end else if (!swScan_ff && !trigLow) begin
          nxt_state = SCE_STBY;
        end else if (tmrAt(tmr_ff, SCAN_CYC)) begin
          nxt_state = SCE_HOLD;
        end
      end
      SCE_SEND: begin
        // Buzzer holds until the last frame has left
        if (lastSent_ff && txReady) begin
          nxt_state = SCE_HOLD;
        end
      end
      SCE_HOLD: begin
        if (!trigLow) begin
          nxt_state = SCE_STBY;
        end
      end
      SCE_SLEEP: begin
        nxt_tmr = '0;
        if (trigLow) begin
          nxt_state = SCE_WAKE;
        end else if (rxAct) begin
          nxt_state = SCE_STBY;
        end
      end
      SCE_WAKE: begin
        // Timer keeps running so the scan limit covers wake-up
        if (!trigLow) begin
          nxt_state = SCE_SLEEP;
        end else if (tmrAt(tmr_ff, WAKE_CYC)) begin
          nxt_state  = SCE_SCAN;
          nxt_swScan = 1'b0;
        end
      end
    endcase
  end

  // Inactivity count in ms; any activity restarts it
  assign active = trigLow || rxAct || state_ff != SCE_STBY;
  always_comb begin
    nxt_msCnt  = msCnt_ff + sce_ms_t'(1);
    nxt_idleMs = idleMs_ff;
    if (active) begin
      nxt_msCnt  = '0;
      nxt_idleMs = '0;
    end else if (msCnt_ff == sce_ms_t'(MS_CYC - 1)) begin
      nxt_msCnt = '0;
      if (idleMs_ff != '1) begin // Saturate, never wrap
        nxt_idleMs = idleMs_ff + sce_idle_t'(1);
      end
    end
  end

  // Pin outputs follow the next state, so they change with it
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_ff    <= SCE_INIT;
      tmr_ff      <= '0;
      msCnt_ff    <= '0;
      idleMs_ff   <= '0;
      swScan_ff   <= 1'b0;
      lastSent_ff <= 1'b0;
      trigMeta_ff <= 1'b1;
      trigSync_ff <= 1'b1;
      illum_ff    <= 1'b0;
      buzz_ff     <= 1'b0;
      sleep_ff    <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      tmr_ff      <= nxt_tmr;
      msCnt_ff    <= nxt_msCnt;
      idleMs_ff   <= nxt_idleMs;
      swScan_ff   <= nxt_swScan;
      lastSent_ff <= nxt_lastSent;
      trigMeta_ff <= trigPin_b;
      trigSync_ff <= trigMeta_ff;
      illum_ff    <= nxt_state == SCE_SCAN;
      buzz_ff     <= nxt_state == SCE_BEEP
                     || nxt_state == SCE_SEND;
      sleep_ff    <= nxt_state == SCE_SLEEP;
    end
  end

  assign illumOn     = illum_ff;
  assign buzzer      = buzz_ff;
  assign sleepActive = sleep_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_sleep_entry;
    state_ff == SCE_STBY && !trigLow && !swCmd && sleepEn
      && idleMs_ff >= sleepMs |=> sleepActive && state_ff == SCE_SLEEP;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("no sleep after idle interval");

  property p_wake_trig;
    state_ff == SCE_WAKE && trigLow && tmrAt(tmr_ff, WAKE_CYC)
      |=> illumOn && !sleepActive;
  endproperty
  a_wake_trig: assert property (p_wake_trig)
    else $error("trigger wake did not start scan");

  property p_wake_rx;
    state_ff == SCE_SLEEP && !trigLow && rxAct
      |=> !sleepActive && state_ff == SCE_STBY;
  endproperty
  a_wake_rx: assert property (p_wake_rx)
    else $error("receive activity did not wake");

  property p_buzz_send;
    $fell(buzzer) && $past(state_ff) == SCE_SEND |-> txReady;
  endproperty
  a_buzz_send: assert property (p_buzz_send)
    else $error("buzzer dropped during transmission");

  property p_scan_limit;
    state_ff == SCE_SCAN |-> tmr_ff < sce_tmr_t'(SCAN_CYC);
  endproperty
  a_scan_limit: assert property (p_scan_limit)
    else $error("scan outlived its limit");

  property p_init;
    state_ff == SCE_INIT |-> tmr_ff < sce_tmr_t'(INIT_CYC)
      && !buzzer && !illumOn;
  endproperty
  a_init: assert property (p_init)
    else $error("initialization too long");

  property p_sw_trig;
    state_ff == SCE_STBY && !trigLow && swCmd
      |=> illumOn ##1 illumOn || state_ff != SCE_SCAN;
  endproperty
  a_sw_trig: assert property (p_sw_trig)
    else $error("serial trigger ignored");

  property p_pwr_beep;
    $rose(buzzer) && $past(state_ff) == SCE_INIT
      |-> !illumOn [*3];
  endproperty
  a_pwr_beep: assert property (p_pwr_beep)
    else $error("power-up indication wrong");

  property p_good_read;
    state_ff == SCE_SCAN && decodeDone
      |=> !illumOn && buzzer && state_ff == SCE_SEND;
  endproperty
  a_good_read: assert property (p_good_read)
    else $error("good read sequence wrong");

  property p_release;
    state_ff == SCE_HOLD && trigLow |=> !illumOn && !buzzer;
  endproperty
  a_release: assert property (p_release)
    else $error("scan restarted without release");

  property p_idle_restart;
    trigLow || rxAct |=> idleMs_ff == '0;
  endproperty
  a_idle_restart: assert property (p_idle_restart)
    else $error("idle interval not restarted");

  c_hw_scan: cover property (state_ff == SCE_SCAN && !swScan_ff
    ##1 state_ff == SCE_SEND);
  c_sw_scan: cover property (swScan_ff && state_ff == SCE_SEND);
  c_sleep_wake: cover property (state_ff == SCE_WAKE
    ##1 state_ff == SCE_SCAN);
  c_timeout: cover property (state_ff == SCE_SCAN
    ##1 state_ff == SCE_HOLD);

endmodule

`default_nettype wire

/* File: rtl/sce_params.svh */
`ifndef SCE_PARAMS_SVH
`define SCE_PARAMS_SVH

// Clock rate
`define SCE_CLK_HZ     100000000
`define SCE_CLK_KHZ    100000

// Operating times in ms
`define SCE_INIT_MS    310
`define SCE_BEEP_MS    100
`define SCE_WAKE_MS    2
`define SCE_SCAN_MS    120

// Serial framing: 8 data, no parity, 1 stop
`define SCE_BAUD       9600
`define SCE_DATA_BITS  8
`define SCE_FRAME_BITS (`SCE_DATA_BITS + 2)
`define SCE_BIT_CYC    ((`SCE_CLK_HZ + `SCE_BAUD / 2) / `SCE_BAUD)

// Receive byte that starts a scan, value arbitrary
`define SCE_SW_TRIG    8'h16

// Counter widths
`define SCE_TMR_W      25
`define SCE_MS_W       17
`define SCE_IDLE_W     16
`define SCE_BAUD_W     14
`define SCE_BIT_W      4

`endif

/* File: rtl/sce_pkg.sv */
`include "sce_params.svh"

package sce_pkg;

  // Gray along init, beep, standby, scan, send, hold
  typedef enum logic [2:0] {
    SCE_INIT  = 3'h0,
    SCE_BEEP  = 3'h1,
    SCE_STBY  = 3'h3,
    SCE_SCAN  = 3'h2,
    SCE_SEND  = 3'h6,
    SCE_HOLD  = 3'h7,
    SCE_SLEEP = 3'h5,
    SCE_WAKE  = 3'h4
  } sce_state_e;

  typedef struct packed {
    logic                      valid;
    logic                      last;
    logic [`SCE_DATA_BITS-1:0] data;
  } sce_byte_s;

  typedef logic [`SCE_TMR_W-1:0]  sce_tmr_t;
  typedef logic [`SCE_MS_W-1:0]   sce_ms_t;
  typedef logic [`SCE_IDLE_W-1:0] sce_idle_t;
  typedef logic [`SCE_BAUD_W-1:0] sce_baud_t;
  typedef logic [`SCE_BIT_W-1:0]  sce_bit_t;

endpackage

/* File: rtl/sce_uart_rx.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sce_params.svh"

module sce_uart_rx
  import sce_pkg::*;
#(
  parameter int BIT_CYC = `SCE_BIT_CYC
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic rxdPin,
  output sce_byte_s rxByte,
  output logic      rxAct
);

  logic                      rx0_ff;
  logic                      rx1_ff;
  logic                      rxPrev_ff;
  logic                      busy_ff;
  logic                      nxt_busy;
  sce_baud_t                 baud_ff;
  sce_baud_t                 nxt_baud;
  sce_bit_t                  bit_ff;
  sce_bit_t                  nxt_bit;
  logic [`SCE_DATA_BITS-1:0] shift_ff;
  logic [`SCE_DATA_BITS-1:0] nxt_shift;
  sce_byte_s                 out_ff;
  sce_byte_s                 nxt_out;
  logic                      fall;

  // Edge seen only past the second sync flop
  assign fall  = rxPrev_ff & ~rx1_ff;
  assign rxAct = fall;

  // Start checked at mid bit, then one sample per bit
  always_comb begin
    nxt_busy  = busy_ff;
    nxt_baud  = baud_ff;
    nxt_bit   = bit_ff;
    nxt_shift = shift_ff;
    nxt_out   = '0;
    if (!busy_ff) begin
      if (fall) begin
        nxt_busy = 1'b1;
        nxt_baud = '0;
        nxt_bit  = '0;
      end
    end else if (baud_ff == (bit_ff == '0
                 ? sce_baud_t'(BIT_CYC / 2 - 1)
                 : sce_baud_t'(BIT_CYC - 1))) begin
      nxt_baud = '0;
      nxt_bit  = bit_ff + sce_bit_t'(1);
      if (bit_ff == '0) begin
        nxt_busy = ~rx1_ff; // Glitch, not a start bit
      end else if (bit_ff <= sce_bit_t'(`SCE_DATA_BITS)) begin
        nxt_shift = {rx1_ff, shift_ff[`SCE_DATA_BITS-1:1]};
      end else begin
        nxt_busy      = 1'b0;
        nxt_out.valid = rx1_ff; // Framing error drops byte
        nxt_out.last  = 1'b1;
        nxt_out.data  = shift_ff;
      end
    end else begin
      nxt_baud = baud_ff + sce_baud_t'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx0_ff    <= 1'b1;
      rx1_ff    <= 1'b1;
      rxPrev_ff <= 1'b1;
      busy_ff   <= 1'b0;
      baud_ff   <= '0;
      bit_ff    <= '0;
      shift_ff  <= '0;
      out_ff    <= '0;
    end else begin
      rx0_ff    <= rxdPin;
      rx1_ff    <= rx0_ff;
      rxPrev_ff <= rx1_ff;
      busy_ff   <= nxt_busy;
      baud_ff   <= nxt_baud;
      bit_ff    <= nxt_bit;
      shift_ff  <= nxt_shift;
      out_ff    <= nxt_out;
    end
  end

  assign rxByte = out_ff;

  property p_rx_pulse;
    @(posedge clock) disable iff (!rst_b)
      rxByte.valid |=> !rxByte.valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("receive strobe longer than one cycle");

endmodule

`default_nettype wire

/* File: rtl/sce_uart_tx.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sce_params.svh"

module sce_uart_tx
  import sce_pkg::*;
#(
  parameter int BIT_CYC = `SCE_BIT_CYC
) (
  input  wire logic      clock,
  input  wire logic      rst_b,
  input  wire sce_byte_s txIn,
  output logic           txReady,
  output logic           txd
);

  logic                        busy_ff;
  logic                        nxt_busy;
  logic [`SCE_FRAME_BITS-1:0]  shift_ff;
  logic [`SCE_FRAME_BITS-1:0]  nxt_shift;
  sce_bit_t                    bit_ff;
  sce_bit_t                    nxt_bit;
  sce_baud_t                   baud_ff;
  sce_baud_t                   nxt_baud;
  logic                        txd_ff;
  logic                        nxt_txd;

  // Frame is start, data LSB first, stop; no flow control
  always_comb begin
    nxt_busy  = busy_ff;
    nxt_shift = shift_ff;
    nxt_bit   = bit_ff;
    nxt_baud  = baud_ff;
    if (!busy_ff) begin
      if (txIn.valid) begin
        nxt_busy  = 1'b1;
        nxt_shift = {1'b1, txIn.data, 1'b0};
        nxt_bit   = '0;
        nxt_baud  = '0;
      end
    end else if (baud_ff == sce_baud_t'(BIT_CYC - 1)) begin
      nxt_baud  = '0;
      nxt_shift = {1'b1, shift_ff[`SCE_FRAME_BITS-1:1]};
      if (bit_ff == sce_bit_t'(`SCE_FRAME_BITS - 1)) begin
        nxt_busy = 1'b0;
      end else begin
        nxt_bit = bit_ff + sce_bit_t'(1);
      end
    end else begin
      nxt_baud = baud_ff + sce_baud_t'(1);
    end
    nxt_txd = nxt_busy ? nxt_shift[0] : 1'b1; // Idle line high
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      busy_ff  <= 1'b0;
      shift_ff <= '1;
      bit_ff   <= '0;
      baud_ff  <= '0;
      txd_ff   <= 1'b1;
    end else begin
      busy_ff  <= nxt_busy;
      shift_ff <= nxt_shift;
      bit_ff   <= nxt_bit;
      baud_ff  <= nxt_baud;
      txd_ff   <= nxt_txd;
    end
  end

  assign txReady = ~busy_ff;
  assign txd     = txd_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_start_bit;
    !busy_ff && txIn.valid |=> !txd && busy_ff;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("start bit not driven low");

  property p_stop_bit;
    busy_ff && bit_ff == sce_bit_t'(`SCE_FRAME_BITS - 1) |-> txd;
  endproperty
  a_stop_bit: assert property (p_stop_bit)
    else $error("stop bit not high");

endmodule

`default_nettype wire

/* File: test/sce_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sce_host_model #(
  parameter int BIT_CYC = 8
) (
  input  wire logic clock,
  output logic      trigPin_b,
  output logic      rxdPin,
  input  wire logic txdPin
);
  logic [7:0] rxQ[$];
  int         frameErr = 0;

  // Idle host: trigger released, receive line at its idle high
  initial begin
    trigPin_b = 1'b1;
    rxdPin    = 1'b1;
  end

  // Pins only move on falling edges, away from the sampling edge
  task automatic pressTrig();
    @(negedge clock);
    trigPin_b = 1'b0;
  endtask

  // Release before any new press, else no new scan starts
  task automatic letGo();
    @(negedge clock);
    trigPin_b = 1'b1;
  endtask

  // LSB first, start 0, stop 1, no parity, no handshake lines
  task automatic sendByte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clock);
      rxdPin = f[i];
      repeat (BIT_CYC - 1) @(negedge clock);
    end
  endtask

  // Frame catcher, samples each bit near its middle
  always begin
    logic [7:0] b;
    @(negedge txdPin);
    repeat (BIT_CYC / 2) @(negedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(negedge clock);
      b[i] = txdPin;
    end
    repeat (BIT_CYC) @(negedge clock);
    if (txdPin !== 1'b1) frameErr++;
    rxQ.push_back(b);
  end
endmodule

`default_nettype wire

/* File: test/tb_scan_engine_host_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sce_params.svh"

module tb_scan_engine_host_control
  import sce_pkg::*;
();
  localparam int INIT_C = 50;
  localparam int BEEP_C = 20;
  localparam int WAKE_C = 10;
  localparam int SCAN_C = 2000;
  localparam int BIT_C  = 8;
  localparam int ILL = 0, BUZ = 1, SLP = 2, RDY = 3;

  logic      clock;
  logic      rst_b;
  logic      trigPin_b;
  logic      rxdPin;
  logic      sleepEn;
  sce_idle_t sleepMs;
  logic      decodeDone;
  sce_byte_s decByte;
  logic      decReady;
  logic      illumOn;
  logic      buzzer;
  logic      txdPin;
  logic      sleepActive;
  int        mismatches = 0;
  int        nChecks = 0;

  sce_host_ctrl #(.INIT_CYC(INIT_C), .BEEP_CYC(BEEP_C), .WAKE_CYC(WAKE_C),
    .SCAN_CYC(SCAN_C), .MS_CYC(10), .BIT_CYC(BIT_C)) dut_u (
    .clock(clock), .rst_b(rst_b), .trigPin_b(trigPin_b), .rxdPin(rxdPin),
    .sleepEn(sleepEn), .sleepMs(sleepMs), .decodeDone(decodeDone),
    .decByte(decByte), .decReady(decReady), .illumOn(illumOn),
    .buzzer(buzzer), .txdPin(txdPin), .sleepActive(sleepActive));

  sce_host_model #(.BIT_CYC(BIT_C)) model (
    .clock(clock), .trigPin_b(trigPin_b), .rxdPin(rxdPin), .txdPin(txdPin));

  // Free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Bounded wait; a hang shows up as a failed check afterwards
  task automatic waitUntil(input int sel, input logic v, input int lim,
                           output int n);
    n = 0;
    while (((sel == ILL) ? illumOn : (sel == BUZ) ? buzzer :
            (sel == SLP) ? sleepActive : decReady) !== v && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic pulseDecode();
    @(negedge clock);
    decodeDone = 1'b1;
    @(negedge clock);
    decodeDone = 1'b0;
  endtask

  // One edge between offers, so valid never toggles twice at once
  task automatic offerByte(input logic [7:0] b, input logic last);
    int n;
    @(negedge clock);
    decByte = '{valid: 1'b1, last: last, data: b};
    waitUntil(RDY, 1'b1, 20 * BIT_C, n);
    check(buzzer, 1'b1);
    @(negedge clock);
    decByte.valid = 1'b0;
  endtask

  // Good read: light off, beep held over the whole transfer
  task automatic goodRead(input logic [7:0] d0, input logic [7:0] d1,
                          input longint t0);
    int n;
    model.rxQ.delete();
    pulseDecode();
    check({illumOn, buzzer}, 2'b01);
    offerByte(d0, 1'b0);
    offerByte(d1, 1'b1);
    ticks(5 * BIT_C);
    check(buzzer, 1'b1);
    waitUntil(BUZ, 1'b0, 12 * BIT_C, n);
    check(buzzer, 1'b0);
    check(($time - t0) / 10 <= SCAN_C, 1'b1);
    ticks(2 * BIT_C);
    check(16'(model.rxQ.size()), 16'h0002);
    if (model.rxQ.size() == 2) begin
      check(model.rxQ[0], d0);
      check(model.rxQ[1], d1);
    end
    check(16'(model.frameErr), 16'h0000);
  endtask

  // Silent init, then one power-up beep into standby
  task automatic powerUp();
    ticks(INIT_C - 3);
    check(buzzer, 1'b0);
    ticks(3 + BEEP_C / 2);
    check(buzzer, 1'b1);
    ticks(BEEP_C / 2 + 3);
    check({buzzer, illumOn}, 2'b00);
  endtask

  // Held trigger: decode, send, then hold off until released
  task automatic hwScan();
    int     n;
    longint t0;
    model.pressTrig();
    t0 = $time;
    waitUntil(ILL, 1'b1, 6, n);
    check(illumOn, 1'b1);
    ticks(30);
    check({illumOn, buzzer}, 2'b10);
    goodRead(8'ha5, 8'h3c, t0);
    ticks(30);
    check(illumOn, 1'b0);
    model.letGo();
  endtask

  // Early release aborts the capture without a beep
  task automatic releaseMid();
    int n;
    model.pressTrig();
    waitUntil(ILL, 1'b1, 6, n);
    check(illumOn, 1'b1);
    model.letGo();
    waitUntil(ILL, 1'b0, 6, n);
    check({illumOn, buzzer}, 2'b00);
  endtask

  // Serial command starts a scan that only decode or the timeout ends
  task automatic swScan();
    int     n;
    longint t0;
    model.sendByte(`SCE_SW_TRIG);
    waitUntil(ILL, 1'b1, 2 * BIT_C, n);
    check(illumOn, 1'b1);
    t0 = $time;
    model.pressTrig();
    ticks(5);
    model.letGo();
    ticks(5);
    check(illumOn, 1'b1);
    waitUntil(ILL, 1'b0, SCAN_C + 20, n);
    check(illumOn, 1'b0);
    check(($time - t0) / 10 <= SCAN_C, 1'b1);
    ticks(5);
    pulseDecode();
    check({illumOn, buzzer, decReady}, 3'b000);
  endtask

  // Idle timer, restart on receive, both wake paths
  task automatic sleepTest();
    int     n;
    longint t0;
    sleepMs = 16'h000a;
    sleepEn = 1'b1;
    ticks(70);
    model.sendByte(8'h55);
    check(sleepActive, 1'b0);
    // Last receive edge lies late in the frame; sleep needs a full interval
    waitUntil(SLP, 1'b1, 160, n);
    check(sleepActive, 1'b1);
    check(n >= 80, 1'b1);
    fork
      model.sendByte(8'h55);
      begin ticks(6); check(sleepActive, 1'b0); end
    join
    waitUntil(SLP, 1'b1, 200, n);
    check(sleepActive, 1'b1);
    model.pressTrig();
    ticks(WAKE_C / 2);
    model.letGo();
    ticks(20);
    check({sleepActive, illumOn}, 2'b10);
    model.pressTrig();
    t0 = $time;
    waitUntil(ILL, 1'b1, WAKE_C + 8, n);
    check({sleepActive, illumOn}, 2'b01);
    goodRead(8'h00, 8'hff, t0);
    model.letGo();
    sleepEn = 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence; inputs change on falling edges only
  initial begin
    rst_b      = 1'b0;
    sleepEn    = 1'b0;
    sleepMs    = '0;
    decodeDone = 1'b0;
    decByte    = '0;
    ticks(3);
    rst_b = 1'b1;
    powerUp();
    hwScan();
    releaseMid();
    swScan();
    sleepTest();
    report_and_stop();
  end

  // Whole run needs about 3100 cycles; cut a hang well beyond that
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end
endmodule

`default_nettype wire
